/* operating_state_indicator.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - blue steady while loading firmware
// - load failure: red five seconds, retry loader
// - terminal detected: relay messages, show violet
// - serial 115200 baud, 8N1
// - send identification escape sequence at start-up
// - blue flashing while firmware starts up
// - slow white pulsation while waiting
// - fast white pulsation while busy
// - fast green pulsation while script runs
// - fast yellow pulsation on warning limit
// - single green pulse after good command
// - single red pulse after failed command
// - critical fault: fast red, block motion
// - software fault: halt, code two short, restart
// - activity LED lit when enabled, flickers
// - query 40h returns status word anytime
// - status word holds status and fault flags
// - ackable faults set emergency halt flag
module operating_state_indicator import osi_pkg::*; #(
  parameter int unsigned N_IF = 3,
  parameter int unsigned ERR_CYCLES = ERR_CYC,
  parameter int unsigned SLOW_CYCLES = SLOW_CYC,
  parameter int unsigned FAST_CYCLES = FAST_CYC,
  parameter int unsigned FLASH_CYCLES = FLASH_CYC,
  parameter int unsigned PULSE_CYCLES = PULSE_CYC,
  parameter int unsigned CODE_CYCLES = CODE_CYC,
  parameter int unsigned RESTART_CYCLES = RESTART_CYC,
  parameter int unsigned ACT_CYCLES = ACT_CYC,
  parameter int unsigned BIT_CYCLES = BIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load_fail,
  input wire logic i_load_done,
  input wire logic i_sys_ready,
  input wire logic i_term_detect,
  input wire logic i_msg_valid,
  input wire logic [7:0] i_msg_byte,
  output logic o_msg_ready,
  input wire logic i_busy,
  input wire logic i_script_run,
  input wire logic i_warn,
  input wire logic i_cmd_ok,
  input wire logic i_cmd_err,
  input wire logic i_crit_fault,
  input wire logic i_fault_ack,
  input wire logic i_sw_fault,
  input wire logic i_homed,
  input wire logic i_temp_warn,
  input wire logic i_power_fail,
  input wire logic [N_IF-1:0] i_if_en,
  input wire logic [N_IF-1:0] i_if_act,
  input wire logic i_rxd,
  output logic o_txd,
  output logic [2:0] o_led_rgb,
  output logic [N_IF-1:0] o_if_led,
  output logic o_motion_enable,
  output logic o_halt,
  output logic o_loader_restart,
  output logic o_sys_restart
);
  if (N_IF < 1 || SLOW_CYCLES < 1024 || FAST_CYCLES < 1024 || FLASH_CYCLES < 2
      || PULSE_CYCLES < 2 || CODE_CYCLES < 16 || ERR_CYCLES < 16
      || RESTART_CYCLES < 2 || ACT_CYCLES < 2) begin : g_chk
    $error("operating_state_indicator: timing parameters too small");
  end

  // 512 ramp steps per pulsation period
  localparam logic [31:0] SL_LAST = 32'(SLOW_CYCLES / 512 - 1);
  localparam logic [31:0] FA_LAST = 32'(FAST_CYCLES / 512 - 1);
  localparam logic [31:0] FL_LAST = 32'(FLASH_CYCLES - 1);
  localparam logic [31:0] CD_LAST = 32'(CODE_CYCLES / 8 - 1);
  localparam logic [31:0] ERR_LAST = 32'(ERR_CYCLES - 1);
  localparam logic [31:0] RS_LAST = 32'(RESTART_CYCLES - 1);
  localparam logic [31:0] OS_LEN = 32'(PULSE_CYCLES);
  localparam logic [31:0] ACT_LEN = 32'(ACT_CYCLES);
  localparam logic [2:0] ID_END = 3'(ID_LEN);

  typedef struct packed {
    boot_t st;
    logic term;
    logic crit;
    logic [31:0] tmr;
    logic ldr_rst;
    logic sys_rst;
    logic [7:0] pwm;
    logic [31:0] sl_div;
    logic [8:0] sl_ramp;
    logic [31:0] fa_div;
    logic [8:0] fa_ramp;
    logic [31:0] fl_div;
    logic fl_lvl;
    logic [31:0] os_cnt;
    logic os_red;
    logic [31:0] cd_div;
    logic [2:0] cd_ph;
    logic [2:0] id_idx;
    logic [1:0] rep_cnt;
    logic [15:0] rep_word;
    rgb_t rgb;
    logic [N_IF-1:0][31:0] act;
    logic [N_IF-1:0] led;
  } st_t;

  st_t s_r;
  st_t s_nxt;
  serial_if sio ();
  logic tx_fire;

  uart_link #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_link (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .sio(sio),
    .i_rxd(i_rxd),
    .o_txd(o_txd)
  );

  // triangle brightness against the pwm sweep gives a soft pulsation
  function automatic logic tri_on(input logic [8:0] ramp, input logic [7:0] pwm);
    tri_on = (ramp[8] ? ~ramp[7:0] : ramp[7:0]) > pwm;
  endfunction : tri_on

  function automatic logic [31:0] count_down(input logic [31:0] c);
    count_down = (c == 32'h0) ? 32'h0 : c - 32'h1;
  endfunction : count_down

  // transmit order: identification, query reply, boot messages
  always_comb begin
    sio.tx_valid = 1'b0;
    sio.tx_byte = 8'h00;
    o_msg_ready = !s_r.term;
    if (s_r.id_idx != ID_END) begin
      sio.tx_valid = 1'b1;
      sio.tx_byte = ID_SEQ[s_r.id_idx];
    end else if (s_r.rep_cnt != 2'h0) begin
      sio.tx_valid = 1'b1;
      sio.tx_byte = (s_r.rep_cnt == 2'h2) ? s_r.rep_word[7:0] : s_r.rep_word[15:8];
    end else if (s_r.term) begin
      sio.tx_valid = i_msg_valid;
      sio.tx_byte = i_msg_byte;
      o_msg_ready = sio.tx_ready;
    end
  end
  assign tx_fire = sio.tx_valid && sio.tx_ready;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ldr_rst = 1'b0;
    s_nxt.sys_rst = 1'b0;
    s_nxt.pwm = s_r.pwm + 8'h01;
    s_nxt.sl_div = (s_r.sl_div >= SL_LAST) ? 32'h0 : s_r.sl_div + 32'h1;
    s_nxt.sl_ramp = s_r.sl_ramp + ((s_r.sl_div >= SL_LAST) ? 9'h001 : 9'h000);
    s_nxt.fa_div = (s_r.fa_div >= FA_LAST) ? 32'h0 : s_r.fa_div + 32'h1;
    s_nxt.fa_ramp = s_r.fa_ramp + ((s_r.fa_div >= FA_LAST) ? 9'h001 : 9'h000);
    s_nxt.fl_div = (s_r.fl_div >= FL_LAST) ? 32'h0 : s_r.fl_div + 32'h1;
    s_nxt.fl_lvl = s_r.fl_lvl ^ (s_r.fl_div >= FL_LAST);
    s_nxt.cd_div = (s_r.cd_div >= CD_LAST) ? 32'h0 : s_r.cd_div + 32'h1;
    s_nxt.cd_ph = s_r.cd_ph + ((s_r.cd_div >= CD_LAST) ? 3'h1 : 3'h0);
    s_nxt.tmr = count_down(s_r.tmr);
    if (i_term_detect) begin
      s_nxt.term = 1'b1;
    end
    // a new fault in the acknowledge cycle stays latched
    if (i_fault_ack) begin
      s_nxt.crit = 1'b0;
    end
    if (i_crit_fault) begin
      s_nxt.crit = 1'b1;
    end
    s_nxt.os_cnt = count_down(s_r.os_cnt);
    if (i_cmd_ok || i_cmd_err) begin
      s_nxt.os_cnt = OS_LEN;
      s_nxt.os_red = i_cmd_err;
    end
    unique case (s_r.st)
      ST_LOAD: begin
        if (i_load_fail) begin
          s_nxt.st = ST_ERR;
          s_nxt.tmr = ERR_LAST;
        end else if (i_load_done) begin
          s_nxt.st = ST_START;
        end
      end
      ST_ERR: begin
        if (s_r.tmr == 32'h0) begin
          s_nxt.st = ST_LOAD;
          s_nxt.ldr_rst = 1'b1;
        end
      end
      ST_START: begin
        if (i_sys_ready) begin
          s_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
      end
      ST_SWF: begin
        if (s_r.tmr == 32'h0) begin
          s_nxt.st = ST_LOAD;
          s_nxt.sys_rst = 1'b1;
          s_nxt.crit = 1'b0;
        end
      end
      default: begin
        s_nxt.st = ST_LOAD;
      end
    endcase
    if (i_sw_fault && (s_r.st == ST_START || s_r.st == ST_RUN)) begin
      s_nxt.st = ST_SWF;
      s_nxt.tmr = RS_LAST;
      s_nxt.cd_div = 32'h0;
      s_nxt.cd_ph = 3'h0;
    end
    if (tx_fire && s_r.id_idx != ID_END) begin
      s_nxt.id_idx = s_r.id_idx + 3'h1;
    end else if (tx_fire && s_r.rep_cnt != 2'h0) begin
      s_nxt.rep_cnt = s_r.rep_cnt - 2'h1;
    end
    if (sio.rx_valid && sio.rx_byte == CMD_GET_STATE) begin
      s_nxt.rep_cnt = 2'h2;
      s_nxt.rep_word = 16'h0000;
      s_nxt.rep_word[SW_HOMED_BIT] = i_homed;
      s_nxt.rep_word[SW_SCRIPT_BIT] = i_script_run;
      s_nxt.rep_word[SW_TEMP_WARN_BIT] = i_temp_warn;
      s_nxt.rep_word[SW_POWER_FAIL_BIT] = i_power_fail;
      s_nxt.rep_word[SW_EMERGENCY_HALT_FLAG_BIT] = s_r.crit;
      s_nxt.rep_word[SW_WARN_BIT] = i_warn;
    end
    unique case (s_r.st)
      ST_LOAD: s_nxt.rgb = s_r.term ? RGB_VIOLET : RGB_BLUE;
      ST_ERR: s_nxt.rgb = RGB_RED;
      ST_START: s_nxt.rgb = s_r.fl_lvl ? RGB_BLUE : RGB_OFF;
      ST_SWF: s_nxt.rgb = CODE_MASK[s_r.cd_ph] ? RGB_RED : RGB_OFF;
      ST_RUN: begin
        if (s_r.crit) begin
          s_nxt.rgb = tri_on(s_r.fa_ramp, s_r.pwm) ? RGB_RED : RGB_OFF;
        end else if (s_r.os_cnt != 32'h0) begin
          s_nxt.rgb = s_r.os_red ? RGB_RED : RGB_GREEN;
        end else if (!tri_on(i_busy || i_warn || i_script_run ? s_r.fa_ramp
            : s_r.sl_ramp, s_r.pwm)) begin
          s_nxt.rgb = RGB_OFF;
        end else if (i_warn) begin
          s_nxt.rgb = RGB_YELLOW;
        end else if (i_script_run) begin
          s_nxt.rgb = RGB_GREEN;
        end else begin
          s_nxt.rgb = RGB_WHITE;
        end
      end
      default: s_nxt.rgb = RGB_OFF;
    endcase
    // traffic darkens the LED for one span, then lit for one span
    for (int i = 0; i < N_IF; i++) begin
      s_nxt.act[i] = count_down(s_r.act[i]);
      if (i_if_act[i] && s_r.act[i] == 32'h0) begin
        s_nxt.act[i] = ACT_LEN + ACT_LEN;
      end
      s_nxt.led[i] = i_if_en[i] && !(s_r.act[i] > ACT_LEN);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_led_rgb = s_r.rgb;
  assign o_if_led = s_r.led;
  assign o_motion_enable = (s_r.st == ST_RUN) && !s_r.crit;
  assign o_halt = (s_r.st == ST_SWF);
  assign o_loader_restart = s_r.ldr_rst;
  assign o_sys_restart = s_r.sys_rst;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  load_blue_a: assert property (s_r.st == ST_LOAD && !s_r.term |=> o_led_rgb == RGB_BLUE)
    else $error("loading not blue");
  err_red_hold_a: assert property ($rose(s_r.st == ST_ERR) |->
    (s_r.st == ST_ERR) [*8] ##1 o_led_rgb == RGB_RED)
    else $error("error red not held");
  err_retry_a: assert property (s_r.st == ST_ERR && s_r.tmr == 32'h0 |=>
    o_loader_restart && s_r.st == ST_LOAD)
    else $error("loader not restarted");
  violet_term_a: assert property (s_r.st == ST_LOAD && s_r.term |=>
    o_led_rgb == RGB_VIOLET)
    else $error("terminal colour not violet");
  id_first_a: assert property ($rose(i_rst_n) |-> sio.tx_valid &&
    sio.tx_byte == 8'h1B)
    else $error("identification does not start with escape");
  start_flash_a: assert property (s_r.st == ST_START |=>
    o_led_rgb == RGB_BLUE || o_led_rgb == RGB_OFF)
    else $error("start phase not blue flash");
  crit_block_a: assert property (s_r.crit |-> !o_motion_enable ##1
    (o_led_rgb == RGB_RED || o_led_rgb == RGB_OFF || $past(s_r.st) != ST_RUN))
    else $error("critical fault not enforced");
  pulse_prio_a: assert property (s_r.st == ST_RUN && !s_r.crit && i_cmd_ok && !i_cmd_err
    ##1 !s_r.crit && s_r.st == ST_RUN |=> o_led_rgb == RGB_GREEN)
    else $error("command pulse not green");
  sw_halt_a: assert property (i_sw_fault && s_r.st == ST_RUN |=>
    o_halt && !o_motion_enable)
    else $error("software fault did not halt");
  query_reply_a: assert property (sio.rx_valid && sio.rx_byte == CMD_GET_STATE |=>
    s_r.rep_cnt == 2'h2 && s_r.rep_word[SW_EMERGENCY_HALT_FLAG_BIT] == $past(s_r.crit))
    else $error("query not answered");
  if_led_off_a: assert property (!i_if_en[0] |=> !o_if_led[0])
    else $error("disabled interface LED lit");

endmodule : operating_state_indicator

/* operating_state_indicator_tb_top.sv */
`timescale 1ns/1ps
module operating_state_indicator_tb_top;
  import osi_pkg::*;
  localparam int unsigned ERR_N = 200;
  localparam int unsigned PULSE_N = 20;
  localparam int unsigned RST_N = 100;
  // shortened bit time keeps the run short; frame shape is unchanged
  localparam int unsigned BIT_N = 434;
  logic i_clk, i_rst_n, lfail, ldone, sready, tdet, mvalid, mready, busy, script, warn;
  logic cok, cerr, crit, ack, swf, homed, twarn, pfail, rxd, txd, motion, halt, lrst, srst;
  logic [7:0] mbyte;
  logic [2:0] en, act, ifled, rgb;
  int failures, n_tests;

  operating_state_indicator #(.ERR_CYCLES(ERR_N), .SLOW_CYCLES(2048), .FAST_CYCLES(1024),
    .FLASH_CYCLES(8), .PULSE_CYCLES(PULSE_N), .CODE_CYCLES(64), .RESTART_CYCLES(RST_N),
    .ACT_CYCLES(10), .BIT_CYCLES(BIT_N)) operating_state_indicator_inst (.i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load_fail(lfail), .i_load_done(ldone), .i_sys_ready(sready), .i_term_detect(tdet),
    .i_msg_valid(mvalid), .i_msg_byte(mbyte), .o_msg_ready(mready), .i_busy(busy),
    .i_script_run(script), .i_warn(warn), .i_cmd_ok(cok), .i_cmd_err(cerr),
    .i_crit_fault(crit), .i_fault_ack(ack), .i_sw_fault(swf), .i_homed(homed),
    .i_temp_warn(twarn), .i_power_fail(pfail), .i_if_en(en), .i_if_act(act), .i_rxd(rxd),
    .o_txd(txd), .o_led_rgb(rgb), .o_if_led(ifled), .o_motion_enable(motion),
    .o_halt(halt), .o_loader_restart(lrst), .o_sys_restart(srst));
  osi_term_model #(.BIT_CYCLES(BIT_N)) osi_term_model_inst (.i_clk(i_clk), .i_line_in(txd),
    .o_line_out(rxd));

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  // pulsing and flashing must show both the colour and dark, nothing else
  task automatic pat(input logic [2:0] col, input int n);
    int hits, offs, bad;
    hits = 0;
    offs = 0;
    bad = 0;
    repeat (n) begin
      tick(1);
      if (rgb === col) hits++;
      else if (rgb === 3'h0) offs++;
      else bad++;
    end
    chk(16'(hits > 0 && offs > 0), 16'h1, "pattern not alternating");
    chk(16'(bad), 16'h0, "foreign colour in pattern");
  endtask : pat

  task automatic t_boot;
    int k;
    chk(rgb, RGB_BLUE, "not blue while loading");
    chk(mready, 1'b1, "message not dropped before terminal");
    lfail = 1'b1;
    tick(1);
    lfail = 1'b0;
    tick(2);
    chk(rgb, RGB_RED, "not red after load failure");
    k = 0;
    while (lrst !== 1'b1 && k < ERR_N + 10) begin
      tick(1);
      k++;
    end
    chk(16'(k >= ERR_N - 3 && k <= ERR_N - 1), 16'h1, "retry delay wrong");
    tick(1);
    chk(rgb, RGB_BLUE, "not blue after retry");
    tdet = 1'b1;
    tick(1);
    tdet = 1'b0;
    tick(2);
    chk(rgb, RGB_VIOLET, "not violet with terminal");
    chk(mready, 1'b0, "message taken while id pending");
    mvalid = 1'b0;
    ldone = 1'b1;
    tick(1);
    ldone = 1'b0;
    pat(RGB_BLUE, 32);
    sready = 1'b1;
    tick(1);
    sready = 1'b0;
    tick(2);
    chk(motion, 1'b1, "motion blocked in run");
    pat(RGB_WHITE, 4096);
  endtask : t_boot

  task automatic t_levels;
    busy = 1'b1;
    pat(RGB_WHITE, 2048);
    script = 1'b1;
    pat(RGB_GREEN, 2048);
    warn = 1'b1;
    pat(RGB_YELLOW, 2048);
    busy = 1'b0;
    script = 1'b0;
    warn = 1'b0;
  endtask : t_levels

  // third pass fires both at once: the failure colour must win
  task automatic t_oneshot;
    for (int i = 0; i < 3; i++) begin
      cok = (i != 1);
      cerr = (i != 0);
      tick(1);
      cok = 1'b0;
      cerr = 1'b0;
      tick(2);
      repeat (PULSE_N - 4) begin
        chk(rgb, (i == 0) ? RGB_GREEN : RGB_RED, "one-shot colour");
        tick(1);
      end
      tick(PULSE_N);
    end
    pat(RGB_WHITE, 4096);
  endtask : t_oneshot

  task automatic t_crit;
    busy = 1'b1;
    crit = 1'b1;
    tick(1);
    crit = 1'b0;
    tick(1);
    chk(motion, 1'b0, "motion allowed in fault");
    pat(RGB_RED, 2048);
    busy = 1'b0;
    crit = 1'b1;
    ack = 1'b1;
    tick(1);
    crit = 1'b0;
    ack = 1'b0;
    tick(2);
    chk(motion, 1'b0, "ack beat new fault");
  endtask : t_crit

  task automatic t_query;
    int k;
    logic [15:0] w;
    w = 16'h0;
    w[SW_HOMED_BIT] = 1'b1;
    w[SW_TEMP_WARN_BIT] = 1'b1;
    w[SW_POWER_FAIL_BIT] = 1'b1;
    w[SW_EMERGENCY_HALT_FLAG_BIT] = 1'b1;
    w[SW_WARN_BIT] = 1'b1;
    homed = 1'b1;
    twarn = 1'b1;
    pfail = 1'b1;
    warn = 1'b1;
    osi_term_model_inst.send_byte(CMD_GET_STATE);
    k = 0;
    while (osi_term_model_inst.rx_q.size() < ID_LEN + 2 && k < 40000) begin
      tick(1);
      k++;
    end
    chk(16'(osi_term_model_inst.rx_q.size()), 16'(ID_LEN + 2), "byte count");
    for (int i = 0; i < ID_LEN; i++) begin
      chk(osi_term_model_inst.rx_q[i], ID_SEQ[i], "id byte");
    end
    chk({osi_term_model_inst.rx_q[ID_LEN + 1], osi_term_model_inst.rx_q[ID_LEN]}, w,
      "status word");
    chk(16'(osi_term_model_inst.bad_frames), 16'h0, "bad frame seen");
    // one boot message byte, offered only until its handshake edge
    mvalid = 1'b1;
    k = 0;
    while (mready !== 1'b1 && k < 10000) begin
      tick(1);
      k++;
    end
    tick(1);
    mvalid = 1'b0;
    k = 0;
    while (osi_term_model_inst.rx_q.size() < ID_LEN + 3 && k < 10000) begin
      tick(1);
      k++;
    end
    chk(16'(osi_term_model_inst.rx_q.size()), 16'(ID_LEN + 3), "message count");
    chk(osi_term_model_inst.rx_q[ID_LEN + 2], 8'h41, "boot message");
    pfail = 1'b0;
    warn = 1'b0;
    ack = 1'b1;
    tick(1);
    ack = 1'b0;
    tick(2);
    chk(motion, 1'b1, "motion still blocked after ack");
  endtask : t_query

  task automatic t_act;
    en = 3'h5;
    tick(2);
    chk(ifled, 3'h5, "enabled leds not lit");
    act = 3'h3;
    tick(1);
    act = 3'h0;
    tick(1);
    chk(ifled, 3'h4, "no flicker on traffic");
    tick(15);
    chk(ifled, 3'h5, "led not relit");
  endtask : t_act

  task automatic t_swf;
    int k;
    swf = 1'b1;
    tick(1);
    swf = 1'b0;
    tick(5);
    chk(halt, 1'b1, "no halt on software fault");
    for (int u = 0; u < 8; u++) begin
      chk(rgb, CODE_MASK[u] ? RGB_RED : RGB_OFF, "flash code");
      tick(8);
    end
    k = 0;
    while (srst !== 1'b1 && k < RST_N + 10) begin
      tick(1);
      k++;
    end
    chk(16'(k >= RST_N - 71 && k <= RST_N - 67), 16'h1, "restart delay wrong");
    tick(2);
    chk(rgb, RGB_VIOLET, "loader not restarted");
    chk(halt, 1'b0, "halt held after restart");
  endtask : t_swf

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // serial frames are long; this bound only catches a dead run
  initial begin
    repeat (90000) @(posedge i_clk);
    failures++;
    $display("[ERR] %0t run hung", $time);
    summarize();
  end

  initial begin
    {lfail, ldone, sready, tdet, busy, script, warn} = 7'h0;
    {cok, cerr, crit, ack, swf, homed, twarn, pfail} = 8'h0;
    en = 3'h0;
    act = 3'h0;
    mbyte = 8'h41;
    mvalid = 1'b1;
    failures = 0;
    n_tests = 0;
    i_rst_n = 1'b0;
    tick(5);
    i_rst_n = 1'b1;
    tick(3);
    t_boot();
    t_levels();
    t_oneshot();
    t_act();
    t_crit();
    t_query();
    t_swf();
    summarize();
  end
endmodule : operating_state_indicator_tb_top

/* osi_pkg.sv */
package osi_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
  localparam int unsigned BAUD = 115_200;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;

  // figures in milliseconds, counts derived from the clock rate
  localparam int unsigned ERR_MS = 5000;
  localparam int unsigned SLOW_MS = 2000;
  localparam int unsigned FAST_MS = 500;
  localparam int unsigned FLASH_MS = 125;
  localparam int unsigned PULSE_MS = 200;
  localparam int unsigned CODE_MS = 1600;
  localparam int unsigned RESTART_MS = 3000;
  localparam int unsigned ACT_MS = 20;
  localparam int unsigned ERR_CYC = ERR_MS * CLK_KHZ;
  localparam int unsigned SLOW_CYC = SLOW_MS * CLK_KHZ;
  localparam int unsigned FAST_CYC = FAST_MS * CLK_KHZ;
  localparam int unsigned FLASH_CYC = FLASH_MS * CLK_KHZ;
  localparam int unsigned PULSE_CYC = PULSE_MS * CLK_KHZ;
  localparam int unsigned CODE_CYC = CODE_MS * CLK_KHZ;
  localparam int unsigned RESTART_CYC = RESTART_MS * CLK_KHZ;
  localparam int unsigned ACT_CYC = ACT_MS * CLK_KHZ;

  // flash code over eight units: on, off, on, then a long pause
  localparam logic [7:0] CODE_MASK = 8'h05;

  localparam logic [7:0] CMD_GET_STATE = 8'h40;
  localparam int unsigned ID_LEN = 5;
  localparam logic [4:0][7:0] ID_SEQ = {8'h3B, 8'h31, 8'h3F, 8'h5B, 8'h1B};

  localparam int unsigned SW_HOMED_BIT = 0;
  localparam int unsigned SW_SCRIPT_BIT = 1;
  localparam int unsigned SW_TEMP_WARN_BIT = 2;
  localparam int unsigned SW_POWER_FAIL_BIT = 3;
  localparam int unsigned SW_EMERGENCY_HALT_FLAG_BIT = 4;
  localparam int unsigned SW_WARN_BIT = 5;

  typedef enum logic [2:0] {
    RGB_OFF = 3'h0,
    RGB_BLUE = 3'h1,
    RGB_GREEN = 3'h2,
    RGB_RED = 3'h4,
    RGB_VIOLET = 3'h5,
    RGB_YELLOW = 3'h6,
    RGB_WHITE = 3'h7
  } rgb_t;

  // gray along load, start, run; error and software fault off path
  typedef enum logic [2:0] {
    ST_LOAD = 3'h0,
    ST_START = 3'h1,
    ST_RUN = 3'h3,
    ST_SWF = 3'h2,
    ST_ERR = 3'h4
  } boot_t;

endpackage : osi_pkg

/* osi_term_model.sv */
`timescale 1ns/1ps
module osi_term_model #(
  parameter int unsigned BIT_CYCLES = 1736
) (
  input wire logic i_clk,
  input wire logic i_line_in,
  output logic o_line_out
);
  logic [7:0] rx_q[$];
  int bad_frames;

  // line rests at mark level between frames
  initial begin
    o_line_out = 1'b1;
    bad_frames = 0;
  end

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frm;
    frm = {1'b1, b, 1'b0};
    @(posedge i_clk);
    #1;
    for (int i = 0; i < 10; i++) begin
      o_line_out = frm[i];
      repeat (BIT_CYCLES) @(posedge i_clk);
      #1;
    end
  endtask : send_byte

  // each byte with a high stop bit is queued, id sequence included; a low stop bit only counts in bad_frames
  initial begin : rx_loop
    logic [7:0] b;
    forever begin
      @(negedge i_line_in);
      repeat (BIT_CYCLES / 2) @(posedge i_clk);
      if (i_line_in === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(posedge i_clk);
          b[i] = i_line_in;
        end
        repeat (BIT_CYCLES) @(posedge i_clk);
        if (i_line_in === 1'b1) begin
          rx_q.push_back(b);
        end else begin
          bad_frames++;
        end
      end
    end
  end
endmodule : osi_term_model

/* serial_if.sv */
`timescale 1ns/1ps
interface serial_if;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_byte;
  logic rx_valid;
  logic [7:0] rx_byte;
  modport port (input tx_valid, input tx_byte, output tx_ready, output rx_valid,
    output rx_byte);
  modport user (output tx_valid, output tx_byte, input tx_ready, input rx_valid,
    input rx_byte);
endinterface : serial_if

/* uart_link.sv */
`timescale 1ns/1ps
module uart_link import osi_pkg::*; #(
  parameter int unsigned BIT_CYCLES = BIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  serial_if.port sio,
  input wire logic i_rxd,
  output logic o_txd
);
  if (BIT_CYCLES < 16 || BIT_CYCLES > 2047) begin : g_chk
    $error("uart_link: bit time out of range");
  end

  localparam logic [10:0] BIT_LAST = 11'(BIT_CYCLES - 1);
  localparam logic [10:0] HALF_LAST = 11'(BIT_CYCLES / 2 - 1);

  typedef struct packed {
    logic [10:0] tcnt;
    logic [3:0] tbits;
    logic [9:0] tsh;
    logic tbusy;
    logic txd;
    logic [10:0] rcnt;
    logic [3:0] rbits;
    logic [7:0] rsh;
    logic rbusy;
    logic rvalid;
    logic [7:0] rbyte;
  } ser_t;

  ser_t s_r;
  ser_t s_nxt;

  assign sio.tx_ready = !s_r.tbusy;
  assign sio.rx_valid = s_r.rvalid;
  assign sio.rx_byte = s_r.rbyte;
  assign o_txd = s_r.txd;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    // 8 data bits lsb first, no parity, one stop bit
    if (!s_r.tbusy) begin
      if (sio.tx_valid) begin
        s_nxt.tsh = {1'b1, sio.tx_byte, 1'b0};
        s_nxt.txd = 1'b0;
        s_nxt.tbits = 4'h9;
        s_nxt.tcnt = BIT_LAST;
        s_nxt.tbusy = 1'b1;
      end
    end else if (s_r.tcnt != 11'h000) begin
      s_nxt.tcnt = s_r.tcnt - 11'h001;
    end else if (s_r.tbits == 4'h0) begin
      s_nxt.tbusy = 1'b0;
    end else begin
      s_nxt.tsh = s_r.tsh >> 1;
      s_nxt.txd = s_r.tsh[1];
      s_nxt.tbits = s_r.tbits - 4'h1;
      s_nxt.tcnt = BIT_LAST;
    end
    // sample mid-bit; a start bit gone high again is a glitch
    if (!s_r.rbusy) begin
      if (!i_rxd) begin
        s_nxt.rbusy = 1'b1;
        s_nxt.rcnt = HALF_LAST;
        s_nxt.rbits = 4'h0;
      end
    end else if (s_r.rcnt != 11'h000) begin
      s_nxt.rcnt = s_r.rcnt - 11'h001;
    end else begin
      s_nxt.rcnt = BIT_LAST;
      s_nxt.rbits = s_r.rbits + 4'h1;
      if (s_r.rbits == 4'h0) begin
        s_nxt.rbusy = !i_rxd;
      end else if (s_r.rbits == 4'h9) begin
        s_nxt.rbusy = 1'b0;
        s_nxt.rvalid = i_rxd;
        s_nxt.rbyte = s_r.rsh;
      end else begin
        s_nxt.rsh = {i_rxd, s_r.rsh[7:1]};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.txd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  start_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sio.tx_valid && sio.tx_ready |=> !o_txd [*8])
    else $error("start bit not driven low");
  line_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !s_r.tbusy && !$past(s_r.tbusy) |-> o_txd)
    else $error("idle line not high");

endmodule : uart_link
